// [include/drs_pkg.sv]
// Purpose: Shared constants and types for the run/stop and homing block
// Assumes: 32-bit register port, single clock mclk at 250 MHz
// Notes: Offsets and field positions named once here
`default_nettype none
package drs_pkg;
  // =====================================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // Motion control word
  localparam logic [7:0] OFF_STAT = 8'h04; // Motion status word
  localparam logic [7:0] OFF_BLK = 8'h08; // Start blocker word
  localparam logic [7:0] OFF_CFG = 8'h0c; // Run configuration
  localparam logic [7:0] OFF_PRESET = 8'h10; // Reference preset value
  localparam logic [7:0] OFF_SEEK = 8'h14; // Reference seek speed
  localparam logic [7:0] OFF_RAMP = 8'h18; // Ramp down step per cycle
  localparam logic [7:0] OFF_IRQ_ST = 8'h1c; // Interrupt status
  localparam logic [7:0] OFF_IRQ_EN = 8'h20; // Interrupt enable
  localparam logic [7:0] OFF_IRQ_CLR = 8'h24; // Interrupt clear
  localparam logic [7:0] OFF_POS = 8'h28; // Actual position
  // =====================================================================
  // Control word fields
  localparam int CTL_SEEK_REF = 24; // Seek reference command
  localparam int CTL_PRESET = 25; // Preset position command
  localparam int CTL_GO_REF = 27; // Go to reference command
  // Status word fields
  localparam int ST_PENDING = 13; // Homing pending flag
  localparam int ST_ACTIVE = 14; // Homing active
  localparam int ST_DONE = 15; // Reference done
  // Config fields
  localparam int CFG_THREE_WIRE = 0; // Momentary start/stop mode
  localparam int CFG_SW_RAMP = 1; // Software ramp halt
  localparam int CFG_SW_FREE = 2; // Software freewheel halt
  localparam int CFG_SW_TLIM = 3; // Software torque limit halt
  // Blocker width
  localparam int BLK_W = 21;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] RAMP_RST = 32'h0000_0001;
  localparam logic [31:0] SEEK_RST = 32'h0000_0100;
  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0; // Homing finished
  localparam int IRQ_STOP = 1; // Output switched off
  localparam int IRQ_BLOCK = 2; // Start request refused
  // =====================================================================
  // Run sequencer states
  typedef enum logic [2:0] {
    RS_IDLE = 3'b000, // Output off
    RS_RUN = 3'b001, // Normal running
    RS_HOME = 3'b010, // Homing sequence
    RS_RAMP = 3'b011, // Ramp stop
    RS_TLIM = 3'b100 // Torque limit stop
  } drs_state_t;
  // Fault and condition inputs, grouped
  typedef struct packed {
    logic faulted;
    logic no_enable;
    logic power_loss;
    logic power_nvm_error;
    logic fw_update;
    logic pulse_count_config_error;
    logic dc_link_charge_pending;
    logic input_config_error;
    logic motion_shutdown;
    logic magnet_motor_feedback_error;
    logic pos_feedback_select_error;
    logic gate_drive_off;
    logic safe_disable_active;
    logic motor_fw_loading;
    logic dc_link_overvoltage;
  } drs_cond_t;
  // Operator inputs, grouped
  typedef struct packed {
    logic start;
    logic stop;
    logic jog;
    logic freewheel;
    logic torque_limit;
    logic ref_found;
  } drs_oper_t;
endpackage
`default_nettype wire

// [core/drs_core.sv]
// Purpose: Run/stop sequencing, homing status and start blocker word
// Assumes: Operator pins asynchronous; condition inputs on mclk
// Notes: Speed reference is a signed count; zero means stopped
`default_nettype none
module drs_core (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Operator pins and conditions
  input wire drs_pkg::drs_oper_t oper_in,
  input wire drs_pkg::drs_cond_t cond_in,
  input wire logic output_at_zero,
  // Power stage and speed path
  output logic gate_enable,
  output logic signed [31:0] speed_ref,
  output logic torque_limit_decel,
  output logic [31:0] actual_position,
  // Interrupt
  output logic irq
);
  // =====================================================================
  // Synchronisers
  drs_pkg::drs_oper_t oper_s1_r; // First stage, read only by second
  drs_pkg::drs_oper_t oper_s2_r; // Usable operator inputs
  drs_pkg::drs_oper_t oper_d_r; // Previous value for edges
  // Two stages, since operator pins arrive from outside
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      oper_s1_r <= '0;
      oper_s2_r <= '0;
      oper_d_r <= '0;
    end
    else
    begin
      oper_s1_r <= oper_in;
      oper_s2_r <= oper_s1_r;
      oper_d_r <= oper_s2_r;
    end
  end
  // =====================================================================
  // Registers
  logic [31:0] ctrl_r; // Motion control word
  logic [31:0] cfg_r; // Run configuration
  logic [31:0] preset_r; // Reference preset value
  logic [31:0] seek_r; // Seek speed
  logic [31:0] ramp_r; // Ramp step
  logic [31:0] pos_r; // Actual position
  logic [2:0] home_st_r; // Pending, active, done
  logic [drs_pkg::IRQ_W-1:0] irq_st_r; // Sticky events
  logic [drs_pkg::IRQ_W-1:0] irq_en_r; // Event enables
  logic [drs_pkg::BLK_W-1:0] blk_w; // Start blocker word
  logic [31:0] stat_w; // Status word view
  drs_pkg::drs_state_t st_r; // Sequencer state
  drs_pkg::drs_state_t st_nxt;
  // Software writes to control and settings
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      ctrl_r <= drs_pkg::CTRL_RST;
      cfg_r <= drs_pkg::CFG_RST;
      preset_r <= '0;
      seek_r <= drs_pkg::SEEK_RST;
      ramp_r <= drs_pkg::RAMP_RST;
      irq_en_r <= '0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        drs_pkg::OFF_CTRL: ctrl_r <= reg_wdata;
        drs_pkg::OFF_CFG: cfg_r <= reg_wdata;
        drs_pkg::OFF_PRESET: preset_r <= reg_wdata;
        drs_pkg::OFF_SEEK: seek_r <= reg_wdata;
        drs_pkg::OFF_RAMP: ramp_r <= reg_wdata;
        drs_pkg::OFF_IRQ_EN: irq_en_r <= reg_wdata[drs_pkg::IRQ_W-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end
  // =====================================================================
  // Start and stop decode
  logic three_wire; // Momentary mode
  logic start_rise; // Start pulse edge
  logic run_req; // Request to enter running
  logic run_drop; // Two-wire input released
  logic stop_free; // Freewheel stop request
  logic stop_tlim; // Torque limit stop request
  logic stop_ramp; // Ramp stop request
  logic blocked; // Any inhibit apart from start/jog
  assign three_wire = cfg_r[drs_pkg::CFG_THREE_WIRE];
  assign start_rise = oper_s2_r.start & ~oper_d_r.start;
  // Three-wire starts on the pulse; two-wire on the held level
  assign run_req = three_wire ? start_rise : oper_s2_r.start;
  assign run_drop = ~three_wire & ~oper_s2_r.start;
  assign stop_free = oper_s2_r.freewheel | cfg_r[drs_pkg::CFG_SW_FREE];
  assign stop_tlim = oper_s2_r.torque_limit | cfg_r[drs_pkg::CFG_SW_TLIM];
  // Three-wire stop pin is a ramp stop
  assign stop_ramp = (three_wire & oper_s2_r.stop) | run_drop
    | cfg_r[drs_pkg::CFG_SW_RAMP];
  assign blocked = |{blk_w[7:0], blk_w[drs_pkg::BLK_W-1:10]};
  // =====================================================================
  // Start blocker word, bit 19 reads zero
  always_comb
  begin
    blk_w = '0;
    blk_w[0] = cond_in.faulted;
    blk_w[1] = cond_in.no_enable;
    blk_w[2] = cfg_r[drs_pkg::CFG_SW_RAMP];
    blk_w[3] = cfg_r[drs_pkg::CFG_SW_FREE];
    blk_w[4] = cfg_r[drs_pkg::CFG_SW_TLIM];
    blk_w[5] = cond_in.power_loss;
    blk_w[6] = cond_in.power_nvm_error;
    blk_w[7] = cond_in.fw_update;
    // Start seen at all, so a refused start also shows here
    blk_w[8] = oper_s2_r.start;
    blk_w[9] = oper_s2_r.jog;
    blk_w[10] = cond_in.pulse_count_config_error;
    blk_w[11] = cond_in.dc_link_charge_pending;
    blk_w[12] = cond_in.input_config_error;
    blk_w[13] = cond_in.motion_shutdown;
    blk_w[14] = cond_in.magnet_motor_feedback_error;
    blk_w[15] = cond_in.pos_feedback_select_error;
    blk_w[16] = cond_in.gate_drive_off;
    blk_w[17] = cond_in.safe_disable_active;
    blk_w[18] = cond_in.motor_fw_loading;
    blk_w[20] = cond_in.dc_link_overvoltage;
  end
  // =====================================================================
  // Run sequencer
  logic home_finish; // Final move done
  assign home_finish = (st_r == drs_pkg::RS_HOME) & oper_s2_r.ref_found;
  // Freewheel beats torque limit, which beats ramp, from any state
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      drs_pkg::RS_IDLE:
      begin
        if (run_req & ~blocked & ~stop_free & ~stop_tlim & ~stop_ramp)
          st_nxt = ctrl_r[drs_pkg::CTL_SEEK_REF] ? drs_pkg::RS_HOME
            : drs_pkg::RS_RUN;
      end
      drs_pkg::RS_RUN, drs_pkg::RS_HOME:
      begin
        if (stop_free)
          st_nxt = drs_pkg::RS_IDLE;
        else if (stop_tlim)
          st_nxt = drs_pkg::RS_TLIM;
        else if (stop_ramp)
          st_nxt = drs_pkg::RS_RAMP;
        else if (home_finish)
          st_nxt = drs_pkg::RS_RUN;
      end
      drs_pkg::RS_RAMP:
      begin
        if (stop_free)
          st_nxt = drs_pkg::RS_IDLE;
        else if (stop_tlim)
          st_nxt = drs_pkg::RS_TLIM;
        else if (output_at_zero && speed_ref == 32'sh0)
          st_nxt = drs_pkg::RS_IDLE;
      end
      drs_pkg::RS_TLIM:
      begin
        if (stop_free || output_at_zero)
          st_nxt = drs_pkg::RS_IDLE;
      end
      default: st_nxt = drs_pkg::RS_IDLE;
    endcase
  end
  // State register
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      st_r <= drs_pkg::RS_IDLE;
    else
      st_r <= st_nxt;
  end
  // Gate is off only in idle, so freewheel drops it on the next edge
  assign gate_enable = (st_r != drs_pkg::RS_IDLE);
  assign torque_limit_decel = (st_r == drs_pkg::RS_TLIM);
  // =====================================================================
  // Speed reference
  logic [31:0] spd_mag; // Magnitude of reference
  logic go_ref; // Return to reference active
  assign spd_mag = speed_ref[31] ? 32'(-speed_ref) : 32'(speed_ref);
  assign go_ref = ctrl_r[drs_pkg::CTL_GO_REF] & home_st_r[2];
  // Ramp steps toward zero by a fixed step; no overshoot past zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      speed_ref <= '0;
    else
    begin
      case (st_nxt)
        drs_pkg::RS_HOME: speed_ref <= signed'(seek_r);
        drs_pkg::RS_RUN:
        begin
          if (go_ref && pos_r != preset_r)
            speed_ref <= (pos_r > preset_r) ? -signed'(seek_r)
              : signed'(seek_r);
          else
            speed_ref <= '0;
        end
        drs_pkg::RS_RAMP:
        begin
          if (spd_mag <= ramp_r)
            speed_ref <= '0;
          else if (speed_ref[31])
            speed_ref <= speed_ref + signed'(ramp_r);
          else
            speed_ref <= speed_ref - signed'(ramp_r);
        end
        default: speed_ref <= '0;
      endcase
    end
  end
  // =====================================================================
  // Actual position: integrates reference, preset overrides
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pos_r <= '0;
    else if (ctrl_r[drs_pkg::CTL_PRESET])
      pos_r <= preset_r;
    else if (home_finish)
      pos_r <= preset_r;
    else
      pos_r <= pos_r + 32'(speed_ref);
  end
  assign actual_position = pos_r;
  // =====================================================================
  // Homing status flags: [0] pending, [1] active, [2] done
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      home_st_r <= '0;
    else
    begin
      // Finish also masks pending, else a stop at finish leaves both set
      home_st_r[0] <= ctrl_r[drs_pkg::CTL_SEEK_REF] & (st_nxt == drs_pkg::RS_IDLE)
        & ~home_st_r[2] & ~home_finish;
      home_st_r[1] <= (st_nxt == drs_pkg::RS_HOME);
      if (home_finish)
        home_st_r[2] <= 1'b1;
      else if (st_nxt == drs_pkg::RS_HOME && st_r != drs_pkg::RS_HOME)
        home_st_r[2] <= 1'b0;
    end
  end
  always_comb
  begin
    stat_w = drs_pkg::STAT_RST;
    stat_w[drs_pkg::ST_PENDING] = home_st_r[0];
    stat_w[drs_pkg::ST_ACTIVE] = home_st_r[1];
    stat_w[drs_pkg::ST_DONE] = home_st_r[2];
  end
  // =====================================================================
  // Interrupts: set wins over clear
  logic [drs_pkg::IRQ_W-1:0] irq_ev; // Event pulses
  logic [drs_pkg::IRQ_W-1:0] irq_clr; // Clear write
  assign irq_ev[drs_pkg::IRQ_DONE] = home_finish;
  assign irq_ev[drs_pkg::IRQ_STOP] = gate_enable & (st_nxt == drs_pkg::RS_IDLE);
  assign irq_ev[drs_pkg::IRQ_BLOCK] = (st_r == drs_pkg::RS_IDLE) & run_req & blocked;
  assign irq_clr = (reg_wr && reg_addr == drs_pkg::OFF_IRQ_CLR)
    ? reg_wdata[drs_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      irq_st_r <= '0;
    else
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
  end
  assign irq = |(irq_st_r & irq_en_r);
  // =====================================================================
  // Read port, data one cycle after strobe
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      reg_rdata <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        drs_pkg::OFF_CTRL: reg_rdata <= ctrl_r;
        drs_pkg::OFF_STAT: reg_rdata <= stat_w;
        drs_pkg::OFF_BLK: reg_rdata <= {11'h000, blk_w};
        drs_pkg::OFF_CFG: reg_rdata <= cfg_r;
        drs_pkg::OFF_PRESET: reg_rdata <= preset_r;
        drs_pkg::OFF_SEEK: reg_rdata <= seek_r;
        drs_pkg::OFF_RAMP: reg_rdata <= ramp_r;
        drs_pkg::OFF_IRQ_ST: reg_rdata <= {29'h0, irq_st_r};
        drs_pkg::OFF_IRQ_EN: reg_rdata <= {29'h0, irq_en_r};
        drs_pkg::OFF_POS: reg_rdata <= pos_r;
        default: reg_rdata <= '0;
      endcase
    end
    else
      reg_rdata <= '0;
  end
  // =====================================================================
  // Checks
  sequence free_req_s;
    gate_enable && stop_free;
  endsequence
  pending_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    home_st_r[0] |-> $past(ctrl_r[drs_pkg::CTL_SEEK_REF]) && !home_st_r[1] && !home_st_r[2])
    else $error("pending flag without seek command");
  active_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r == drs_pkg::RS_HOME) |-> home_st_r[1])
    else $error("active flag low during homing");
  done_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
    home_finish && !stop_free && !stop_tlim && !stop_ramp |=> home_st_r[2] && !home_st_r[1])
    else $error("done flag not set after finish");
  flags_excl_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !(home_st_r[1] && home_st_r[2]))
    else $error("active and done both set");
  preset_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_r[drs_pkg::CTL_PRESET] |=> pos_r == $past(preset_r))
    else $error("position not preset");
  free_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
    free_req_s |=> !gate_enable)
    else $error("freewheel did not drop gate");
  tlim_prio_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r == drs_pkg::RS_RUN) && stop_tlim && !stop_free |=> st_r == drs_pkg::RS_TLIM)
    else $error("torque limit stop priority wrong");
  tlim_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r == drs_pkg::RS_TLIM) |-> speed_ref == 32'sh0 && torque_limit_decel)
    else $error("torque limit stop reference not zero");
  ramp_down_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r == drs_pkg::RS_RAMP) && $past(st_r == drs_pkg::RS_RAMP) |-> spd_mag <= $past(spd_mag))
    else $error("ramp stop reference grew");
  blk_start_a: assert property (@(posedge mclk) disable iff (!reset_n)
    blk_w[8] == oper_s2_r.start && blk_w[9] == oper_s2_r.jog && !blk_w[19])
    else $error("blocker jog or spare bit wrong");
  // Start taken in idle with seek set and nothing in the way
  sequence seek_start_s;
    (st_r == drs_pkg::RS_IDLE) && ctrl_r[drs_pkg::CTL_SEEK_REF] && run_req && !blocked
      && !stop_free && !stop_tlim && !stop_ramp;
  endsequence
  home_begin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    seek_start_s |=> st_r == drs_pkg::RS_HOME)
    else $error("homing did not begin on start");
  finish_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
    home_finish |=> home_st_r[2] && !home_st_r[0] && pos_r == $past(preset_r))
    else $error("finish left pending set or position wrong");
  goref_speed_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r == drs_pkg::RS_RUN) |-> spd_mag == 32'h0 || spd_mag == $past(seek_r))
    else $error("return move not at seek speed");
  ramp_prio_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (st_r == drs_pkg::RS_RUN) && stop_ramp && !stop_free && !stop_tlim
    |=> st_r == drs_pkg::RS_RAMP)
    else $error("ramp stop not taken");
endmodule
`default_nettype wire

// [verif/drs_stage_model.sv]
// Purpose: Power stage model facing the run/stop block
// Assumes: Same clock as the block; lag set by the bench
// Notes: Reports output at zero after speed stays zero for lag cycles, or at once while the gate is off
`default_nettype none
module drs_stage_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Drive side
  input wire logic gate_enable,
  input wire logic signed [31:0] speed_ref,
  // Bench control
  input wire logic [3:0] lag,
  // Report back
  output logic output_at_zero
);
  // =====================================================================
  // Decay counter
  logic [3:0] zero_cnt_r; // Cycles spent at zero reference
  // Counts how long the reference has sat at zero; slow lag mimics inertia
  always_ff @(posedge mclk)
  begin
    if (!reset_n || speed_ref != 32'sh0)
      zero_cnt_r <= 4'h0;
    else if (zero_cnt_r != 4'hf)
      zero_cnt_r <= zero_cnt_r + 4'h1;
  end
  // Output switched off reads as zero, never a stale level
  assign output_at_zero = !gate_enable || (zero_cnt_r >= lag);
endmodule
`default_nettype wire

// [verif/tb_drive_run_stop_and_homing_status.sv]
// Purpose: Self-checking bench for the run/stop and homing block
// Assumes: 250 MHz mclk, synchronous active-low reset
// Notes: Blocker bits by table, stop types and homing by hand
`default_nettype none
module tb_drive_run_stop_and_homing_status;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // Signals
  logic mclk, reset_n, reg_wr, reg_rd, output_at_zero, gate_enable, torque_limit_decel, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, actual_position, d, mag;
  logic signed [31:0] speed_ref;
  logic [3:0] lag;
  drs_pkg::drs_oper_t oper_in;
  drs_pkg::drs_cond_t cond_in;
  int fails = 0;
  int total_checks = 0;
  int n;
  // Table rows: source (cond bit, or 100 + cfg bit) beside blocker bit
  typedef struct {int src; int dst;} drs_row_t;
  drs_row_t rows[18] = '{'{14, 0}, '{13, 1}, '{12, 5}, '{11, 6}, '{10, 7}, '{9, 10},
    '{8, 11}, '{7, 12}, '{6, 13}, '{5, 14}, '{4, 15}, '{3, 16}, '{2, 17}, '{1, 18},
    '{0, 20}, '{101, 2}, '{102, 3}, '{103, 4}};
  // =====================================================================
  // Instances
  drs_core drs_core_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .oper_in(oper_in), .cond_in(cond_in), .output_at_zero(output_at_zero),
    .gate_enable(gate_enable), .speed_ref(speed_ref), .torque_limit_decel(torque_limit_decel),
    .actual_position(actual_position), .irq(irq));
  drs_stage_model drs_stage_model_i (.mclk(mclk), .reset_n(reset_n),
    .gate_enable(gate_enable), .speed_ref(speed_ref), .lag(lag),
    .output_at_zero(output_at_zero));
  // =====================================================================
  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // =====================================================================
  // Tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    // Return on an edge so the next stimulus lands on it
    @(posedge mclk);
  endtask
  // Bounded wait on the gate, then compare
  task automatic wait_gate(input logic v, input int bound);
    for (int i = 0; i < bound; i++)
    begin
      @(posedge mclk);
      #1;
      if (gate_enable === v)
        break;
    end
    check("gate_enable", {31'h0, gate_enable}, {31'h0, v});
    @(posedge mclk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // =====================================================================
  // Watchdog: whole run is a few hundred cycles
  initial
  begin
    #80000;
    fails++;
    give_verdict();
  end
  // =====================================================================
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    oper_in = '0;
    cond_in = '0;
    lag = 4'h3;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    // Reset values and read-only places
    rd(drs_pkg::OFF_SEEK, d); check("seek reset", d, drs_pkg::SEEK_RST);
    rd(drs_pkg::OFF_RAMP, d); check("ramp reset", d, drs_pkg::RAMP_RST);
    wr(drs_pkg::OFF_STAT, 32'hffff_ffff);
    rd(drs_pkg::OFF_STAT, d); check("status ro", d, drs_pkg::STAT_RST);
    rd(8'h30, d); check("unmapped", d, 32'h0);
    check("gate reset", {31'h0, gate_enable}, 32'h0);
    // Blocker table
    foreach (rows[i])
    begin
      cond_in <= drs_pkg::drs_cond_t'((rows[i].src < 100) ? (15'h1 << rows[i].src) : 15'h0);
      wr(drs_pkg::OFF_CFG, (rows[i].src >= 100) ? (32'h1 << (rows[i].src - 100)) : 32'h0);
      rd(drs_pkg::OFF_BLK, d);
      check("blocker", d, 32'h1 << rows[i].dst);
    end
    cond_in <= '0;
    wr(drs_pkg::OFF_CFG, 32'h0);
    oper_in.jog <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(drs_pkg::OFF_BLK, d); check("jog bit", d, 32'h200);
    oper_in.jog <= 1'b0;
    // Blocked start: faulted and start present, refusal raises irq status
    cond_in <= drs_pkg::drs_cond_t'(15'h4000);
    oper_in.start <= 1'b1;
    repeat (8) @(posedge mclk);
    check("blocked gate", {31'h0, gate_enable}, 32'h0);
    rd(drs_pkg::OFF_BLK, d); check("start bit", d, 32'h101);
    rd(drs_pkg::OFF_IRQ_ST, d); check("irq refused", d & 32'h4, 32'h4);
    oper_in.start <= 1'b0;
    repeat (4) @(posedge mclk);
    cond_in <= '0;
    wr(drs_pkg::OFF_IRQ_CLR, 32'h7);
    // Preset loads position
    wr(drs_pkg::OFF_PRESET, 32'h1234);
    wr(drs_pkg::OFF_CTRL, 32'h1 << drs_pkg::CTL_PRESET);
    repeat (2) @(posedge mclk);
    #1 check("preset pos", actual_position, 32'h1234);
    // Homing: pending, active, done
    wr(drs_pkg::OFF_SEEK, 32'h10);
    wr(drs_pkg::OFF_RAMP, 32'h4);
    wr(drs_pkg::OFF_PRESET, 32'h55);
    wr(drs_pkg::OFF_CTRL, 32'h1 << drs_pkg::CTL_SEEK_REF);
    rd(drs_pkg::OFF_STAT, d); check("pending", d & 32'he000, 32'h2000);
    oper_in.start <= 1'b1;
    wait_gate(1'b1, 6);
    rd(drs_pkg::OFF_STAT, d); check("active", d & 32'he000, 32'h4000);
    check("seek speed", speed_ref, 32'h10);
    oper_in.ref_found <= 1'b1;
    repeat (3) @(posedge mclk);
    oper_in.ref_found <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(drs_pkg::OFF_STAT, d); check("done", d & 32'he000, 32'h8000);
    check("home pos", actual_position, 32'h55);
    check("hold zero", speed_ref, 32'h0);
    // Interrupt raised, masked, cleared
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(drs_pkg::OFF_IRQ_EN, 32'h1);
    #1 check("irq high", {31'h0, irq}, 32'h1);
    wr(drs_pkg::OFF_IRQ_CLR, 32'h1);
    #1 check("irq cleared", {31'h0, irq}, 32'h0);
    // Go to reference at seek speed
    wr(drs_pkg::OFF_PRESET, 32'h155);
    wr(drs_pkg::OFF_CTRL, 32'h1 << drs_pkg::CTL_GO_REF);
    repeat (2) @(posedge mclk);
    #1 mag = (speed_ref < 0) ? -speed_ref : speed_ref;
    check("goref speed", mag, 32'h10);
    @(posedge mclk);
    // Two-wire release: ramp down, gate held until stage at zero
    oper_in.start <= 1'b0;
    n = 0;
    while (speed_ref !== 32'sh0 && n < 20)
    begin
      @(posedge mclk);
      #1 n++;
    end
    check("ramp not jump", {31'h0, n >= 5}, 32'h1);
    check("ramp keeps gate", {31'h0, gate_enable}, 32'h1);
    wait_gate(1'b0, 10);
    // Torque limit stop with a slow stage
    lag <= 4'h8;
    oper_in.start <= 1'b1;
    wait_gate(1'b1, 6);
    oper_in.torque_limit <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 check("tlim decel", {31'h0, torque_limit_decel}, 32'h1);
    check("tlim zero ref", speed_ref, 32'h0);
    check("tlim gate held", {31'h0, gate_enable}, 32'h1);
    wait_gate(1'b0, 15);
    oper_in.start <= 1'b0;
    @(posedge mclk);
    oper_in.torque_limit <= 1'b0;
    // Freewheel, torque limit and stop pin at once (stop pin no ramp stop in two-wire): freewheel wins, no torque phase
    lag <= 4'h3;
    repeat (3) @(posedge mclk);
    oper_in.start <= 1'b1;
    wait_gate(1'b1, 6);
    oper_in.freewheel <= 1'b1;
    oper_in.torque_limit <= 1'b1;
    oper_in.stop <= 1'b1;
    n = 0;
    repeat (4)
    begin
      @(posedge mclk);
      #1 n += (torque_limit_decel !== 1'b0);
    end
    check("free gate off", {31'h0, gate_enable}, 32'h0);
    check("free no tlim", n, 32'h0);
    @(posedge mclk);
    oper_in.start <= 1'b0;
    @(posedge mclk);
    oper_in <= '0;
    // Three-wire: momentary start, momentary stop
    wr(drs_pkg::OFF_CFG, 32'h1);
    oper_in.start <= 1'b1;
    repeat (2) @(posedge mclk);
    oper_in.start <= 1'b0;
    wait_gate(1'b1, 6);
    repeat (6) @(posedge mclk);
    #1 check("3w latched", {31'h0, gate_enable}, 32'h1);
    @(posedge mclk);
    oper_in.stop <= 1'b1;
    repeat (2) @(posedge mclk);
    oper_in.stop <= 1'b0;
    wait_gate(1'b0, 30);
    give_verdict();
  end
endmodule
`default_nettype wire
